// File: gpr_map.svh
`ifndef GPR_MAP_SVH
`define GPR_MAP_SVH

// ----------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------
`define GPR_OFS_PORT_C_DIRECTION 8'h08
`define GPR_OFS_PORT_D_DIRECTION 8'h0c
`define GPR_OFS_PORT_A_LEVEL     8'h10
`define GPR_OFS_PORT_B_LEVEL     8'h14
`define GPR_OFS_PORT_C_LEVEL     8'h18
`define GPR_OFS_PORT_D_LEVEL     8'h1c
`define GPR_OFS_PORT_A_PULLUP    8'h20
`define GPR_OFS_CLOCK_GATES      8'h38

// ----------------------------------------
// Field positions
// ----------------------------------------
`define GPR_BIT_PORT_UNIT_GATE   22

// ----------------------------------------
// Reset values
// ----------------------------------------
`define GPR_RST_DIR_C            16'hffff
`define GPR_RST_DIR_D            12'hfff
`define GPR_RST_LEVEL_16         16'hffff
`define GPR_RST_LEVEL_B          15'h7fff
`define GPR_RST_LEVEL_D          12'hfff
`define GPR_RST_PULLUP_A         16'h0000

`endif

// File: gpr_pkg.sv
package gpr_pkg;

	// ----------------------------------------
	// Pin groups
	// ----------------------------------------
	typedef struct packed {
		logic [15:0] a;
		logic [15:0] b;
		logic [15:0] c;
		logic [11:0] d;
	} gpr_pins_s;

	// ----------------------------------------
	// Synchroniser state
	// ----------------------------------------
	typedef struct packed {
		gpr_pins_s meta;
		gpr_pins_s stable;
	} gpr_sync_s;

	// ----------------------------------------
	// Register bank state
	// ----------------------------------------
	typedef struct packed {
		logic [15:0] dir_a;
		logic [15:0] dir_b;
		logic [15:0] dir_c;
		logic [11:0] dir_d;
		logic [15:0] lvl_a;
		logic [15:1] lvl_b;
		logic [15:0] lvl_c;
		logic [11:0] lvl_d;
		logic [15:0] pu_a;
		logic        gate;
		gpr_pins_s   smp;
		gpr_pins_s   out;
		gpr_pins_s   oe;
		logic [15:0] pu_out;
		logic        ack;
		logic [31:0] rdat;
	} gpr_state_s;

endpackage

// File: gpr_pin_sync.sv
`timescale 1ns/10ps

module gpr_pin_sync
(
	// Clock and reset
	input  wire logic              clk_i,
	input  wire logic              rst_i,
	// Pins in and synchronised out
	input  wire gpr_pkg::gpr_pins_s pin_i,
	output      gpr_pkg::gpr_pins_s pin_o
);

	gpr_pkg::gpr_sync_s st;
	gpr_pkg::gpr_sync_s next_st;

	// ----------------------------------------
	// Two stages per pin
	// ----------------------------------------
	always_comb
	begin
		next_st        = st;
		next_st.meta   = pin_i;
		next_st.stable = st.meta;
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			st <= '0;
		else
			st <= next_st;
	end

	assign pin_o = st.stable;

endmodule

// File: gpr_regs.sv
`timescale 1ns/10ps
`include "gpr_map.svh"

// Notes on behaviour
// - Group C direction bit zero drives its pin, one makes it input.
// - Group D direction has bits eleven to zero, same encoding, upper bits reserved.
// - After reset all group C and D direction bits are one.
// - Group A output pins drive the stored level bit: one high, zero low.
// - Level reads return sampled pin for inputs, stored value for outputs.
// - Group B level has bits fifteen to one; bit zero reserved, no pin.
// - Group C level has all sixteen bits with the same drive and read-back.
// - Group D level has bits eleven to zero; bits above are reserved.
// - Group A pull-up bit one enables the pin pull-up, zero disables it.
// - Port works only while the unit clock gate bit is one; resets zero.

module gpr_regs
(
	// Clock and reset
	input  wire logic               clk_i,
	input  wire logic               rst_i,
	// Wishbone slave
	input  wire logic               wb_cyc_i,
	input  wire logic               wb_stb_i,
	input  wire logic               wb_we_i,
	input  wire logic [7:0]         wb_adr_i,
	input  wire logic [3:0]         wb_sel_i,
	input  wire logic [31:0]        wb_dat_i,
	output      logic [31:0]        wb_dat_o,
	output      logic               wb_ack_o,
	// Group A and B directions from neighbouring logic
	input  wire logic [15:0]        dir_a_i,
	input  wire logic [15:0]        dir_b_i,
	// Pins
	input  wire gpr_pkg::gpr_pins_s pin_lvl_i,
	output      gpr_pkg::gpr_pins_s pin_out_o,
	output      gpr_pkg::gpr_pins_s pin_oe_o,
	output      logic [15:0]        pullup_a_o
);

	gpr_pkg::gpr_state_s st;
	gpr_pkg::gpr_state_s next_st;
	gpr_pkg::gpr_pins_s  pin_sync;

	logic        req;
	logic        wr;
	logic [31:0] wmask;
	logic [31:0] wval;
	logic [31:0] rval;
	logic        port_wr;

	// ----------------------------------------
	// Pin synchroniser
	// ----------------------------------------
	gpr_pin_sync u_sync
	(
		.clk_i (clk_i),
		.rst_i (rst_i),
		.pin_i (pin_lvl_i),
		.pin_o (pin_sync)
	);

	// ----------------------------------------
	// Bus decode
	// ----------------------------------------
	assign req     = wb_cyc_i & wb_stb_i & ~st.ack;
	assign wr      = req & wb_we_i;
	assign port_wr = wr & st.gate;
	assign wmask   = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

	// ----------------------------------------
	// Read mux
	// ----------------------------------------
	always_comb
	begin
		rval = 32'h0000_0000;
		case (wb_adr_i)
			`GPR_OFS_PORT_C_DIRECTION:
				rval = {16'h0000, st.dir_c};
			`GPR_OFS_PORT_D_DIRECTION:
				rval = {20'h00000, st.dir_d};
			`GPR_OFS_PORT_A_LEVEL:
				rval = {16'h0000, (st.dir_a & st.smp.a) | (~st.dir_a & st.lvl_a)};
			`GPR_OFS_PORT_B_LEVEL:
				rval = {16'h0000, (st.dir_b[15:1] & st.smp.b[15:1]) | (~st.dir_b[15:1] & st.lvl_b), 1'b0};
			`GPR_OFS_PORT_C_LEVEL:
				rval = {16'h0000, (st.dir_c & st.smp.c) | (~st.dir_c & st.lvl_c)};
			`GPR_OFS_PORT_D_LEVEL:
				rval = {20'h00000, (st.dir_d & st.smp.d) | (~st.dir_d & st.lvl_d)};
			`GPR_OFS_PORT_A_PULLUP:
				rval = {16'h0000, st.pu_a};
			`GPR_OFS_CLOCK_GATES:
				rval = 32'(st.gate) << `GPR_BIT_PORT_UNIT_GATE;
			default:
				rval = 32'h0000_0000;
		endcase
	end

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb
	begin
		next_st      = st;
		wval         = 32'h0000_0000;
		next_st.ack  = req;
		next_st.rdat = (req & ~wb_we_i) ? rval : 32'h0000_0000;

		// Directions of A and B follow neighbouring logic, except B bit zero, held at one
		next_st.dir_a = dir_a_i;
		next_st.dir_b = {dir_b_i[15:1], 1'b1};

		// Sample frozen while the unit is off
		if (st.gate)
			next_st.smp = pin_sync;

		if (wr && wb_adr_i == `GPR_OFS_CLOCK_GATES)
		begin
			wval         = (32'(st.gate) << `GPR_BIT_PORT_UNIT_GATE) & ~wmask | wb_dat_i & wmask;
			next_st.gate = wval[`GPR_BIT_PORT_UNIT_GATE];
		end

		if (port_wr)
		begin
			case (wb_adr_i)
				`GPR_OFS_PORT_C_DIRECTION:
				begin
					wval          = {16'h0000, st.dir_c} & ~wmask | wb_dat_i & wmask;
					next_st.dir_c = wval[15:0];
				end
				`GPR_OFS_PORT_D_DIRECTION:
				begin
					wval          = {20'h00000, st.dir_d} & ~wmask | wb_dat_i & wmask;
					next_st.dir_d = wval[11:0];
				end
				`GPR_OFS_PORT_A_LEVEL:
				begin
					wval          = {16'h0000, st.lvl_a} & ~wmask | wb_dat_i & wmask;
					next_st.lvl_a = wval[15:0];
				end
				`GPR_OFS_PORT_B_LEVEL:
				begin
					wval          = {16'h0000, st.lvl_b, 1'b0} & ~wmask | wb_dat_i & wmask;
					next_st.lvl_b = wval[15:1];
				end
				`GPR_OFS_PORT_C_LEVEL:
				begin
					wval          = {16'h0000, st.lvl_c} & ~wmask | wb_dat_i & wmask;
					next_st.lvl_c = wval[15:0];
				end
				`GPR_OFS_PORT_D_LEVEL:
				begin
					wval          = {20'h00000, st.lvl_d} & ~wmask | wb_dat_i & wmask;
					next_st.lvl_d = wval[11:0];
				end
				`GPR_OFS_PORT_A_PULLUP:
				begin
					wval         = {16'h0000, st.pu_a} & ~wmask | wb_dat_i & wmask;
					next_st.pu_a = wval[15:0];
				end
				default:
					wval = 32'h0000_0000;
			endcase
		end

		// Pin drive, registered
		next_st.out.a  = next_st.lvl_a;
		next_st.out.b  = {next_st.lvl_b, 1'b0};
		next_st.out.c  = next_st.lvl_c;
		next_st.out.d  = next_st.lvl_d;
		next_st.oe.a   = {16{next_st.gate}} & ~next_st.dir_a;
		next_st.oe.b   = {16{next_st.gate}} & ~next_st.dir_b;
		next_st.oe.c   = {16{next_st.gate}} & ~next_st.dir_c;
		next_st.oe.d   = {12{next_st.gate}} & ~next_st.dir_d;
		next_st.pu_out = {16{next_st.gate}} & next_st.pu_a;
	end

	// ----------------------------------------
	// State register
	// ----------------------------------------
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			st       <= '0;
			st.dir_a <= 16'hffff;
			st.dir_b <= 16'hffff;
			st.dir_c <= `GPR_RST_DIR_C;
			st.dir_d <= `GPR_RST_DIR_D;
			st.lvl_a <= `GPR_RST_LEVEL_16;
			st.lvl_b <= `GPR_RST_LEVEL_B;
			st.lvl_c <= `GPR_RST_LEVEL_16;
			st.lvl_d <= `GPR_RST_LEVEL_D;
			st.pu_a  <= `GPR_RST_PULLUP_A;
			st.gate  <= 1'b0;
		end
		else
			st <= next_st;
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign wb_dat_o   = st.rdat;
	assign wb_ack_o   = st.ack;
	assign pin_out_o  = st.out;
	assign pin_oe_o   = st.oe;
	assign pullup_a_o = st.pu_out;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking cb @(posedge clk_i);
	endclocking

	default disable iff (rst_i);

	chk_dir_reset_ones: assert property ($past(rst_i) |-> st.dir_c == 16'hffff && st.dir_d == 12'hfff)
		else $error("direction not all ones after reset");

	chk_dir_c_drive: assert property (##1 pin_oe_o.c == ({16{st.gate}} & ~st.dir_c))
		else $error("group C enable does not follow direction");

	chk_dir_d_write: assert property (port_wr && wb_adr_i == 8'h0c && wb_sel_i == 4'hf
		|=> st.dir_d == $past(wb_dat_i[11:0]) && wb_ack_o)
		else $error("group D direction write lost");

	chk_level_a_drive: assert property (port_wr && wb_adr_i == 8'h10 && wb_sel_i[0]
		|=> pin_out_o.a[7:0] == $past(wb_dat_i[7:0]))
		else $error("group A drive level wrong");

	chk_read_mix_c: assert property (req && !wb_we_i && wb_adr_i == 8'h18
		|=> wb_dat_o == {16'h0000, ($past(st.dir_c) & $past(st.smp.c)) | (~$past(st.dir_c) & $past(st.lvl_c))})
		else $error("group C level read-back wrong");

	chk_b_bit0_idle: assert property (pin_oe_o.b[0] == 1'b0 && pin_out_o.b[0] == 1'b0)
		else $error("group B bit zero active");

	chk_d_upper_zero: assert property (wb_ack_o && $past(wb_adr_i) inside {8'h0c, 8'h1c}
		|-> wb_dat_o[31:12] == 20'h00000)
		else $error("group D upper bits not zero");

	chk_pullup_gate: assert property (##1 pullup_a_o == ({16{st.gate}} & st.pu_a))
		else $error("pull-up output wrong");

	chk_gate_blocks: assert property (!st.gate && wr && wb_adr_i != 8'h38
		|=> $stable(st.dir_c) && $stable(st.lvl_a) && $stable(st.pu_a) && pin_oe_o == '0)
		else $error("port changed while gated off");

	chk_resv_zero: assert property (wb_ack_o && $past(wb_adr_i) != 8'h38 |-> wb_dat_o[31:16] == 16'h0000)
		else $error("reserved bits read non-zero");

	chk_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack longer than one cycle");

	chk_ack_follows: assert property (req |=> wb_ack_o)
		else $error("request not acknowledged");

	chk_dat_idle_zero: assert property (!wb_ack_o |-> wb_dat_o == 32'h0000_0000)
		else $error("read data not zero outside ack");

	chk_dir_c_write: assert property (port_wr && wb_adr_i == 8'h08 && wb_sel_i == 4'hf
		|=> pin_oe_o.c == ~$past(wb_dat_i[15:0]))
		else $error("group C direction write not driven");

	chk_read_mix_a: assert property (req && !wb_we_i && wb_adr_i == 8'h10
		|=> wb_dat_o[15:0] == (($past(st.dir_a) & $past(st.smp.a)) | (~$past(st.dir_a) & $past(st.lvl_a))))
		else $error("group A level read-back wrong");

	chk_level_b_read: assert property (req && !wb_we_i && wb_adr_i == 8'h14 |=> wb_dat_o[0] == 1'b0)
		else $error("group B bit zero reads one");

	chk_level_c_drive: assert property (port_wr && wb_adr_i == 8'h18 && wb_sel_i == 4'hf
		|=> pin_out_o.c == $past(wb_dat_i[15:0]))
		else $error("group C drive level wrong");

	chk_level_d_drive: assert property (port_wr && wb_adr_i == 8'h1c && wb_sel_i[1:0] == 2'b11
		|=> pin_out_o.d == $past(wb_dat_i[11:0]))
		else $error("group D drive level wrong");

	chk_pullup_write: assert property (port_wr && wb_adr_i == 8'h20 && wb_sel_i == 4'hf
		|=> st.pu_a == $past(wb_dat_i[15:0]))
		else $error("pull-up write lost");

	chk_gate_write: assert property (wr && wb_adr_i == 8'h38 && wb_sel_i[2]
		|=> st.gate == $past(wb_dat_i[`GPR_BIT_PORT_UNIT_GATE]))
		else $error("gate bit write lost");

	chk_sample_frozen: assert property (!st.gate |=> st.smp == $past(st.smp))
		else $error("pins sampled while gated off");

	chk_gate_off_idle: assert property (!st.gate |-> pin_oe_o == '0 && pullup_a_o == 16'h0000)
		else $error("drive or pull-up while gated off");

	cov_gate_on: cover property (wr && wb_adr_i == 8'h38 ##1 st.gate);

	cov_dir_c_out: cover property (port_wr && wb_adr_i == 8'h08 ##1 pin_oe_o.c != 16'h0000);

	cov_read_d: cover property (req && !wb_we_i && wb_adr_i == 8'h1c ##1 wb_ack_o);

	cov_gated_write: cover property (!st.gate && wr && wb_adr_i == 8'h10);

	cov_input_read: cover property (req && !wb_we_i && wb_adr_i == 8'h18 && st.dir_c == 16'hffff ##1 wb_ack_o);

endmodule

// File: gpr_pin_model.sv
`timescale 1ns/10ps

module gpr_pin_model
(
	// Clock
	input  wire logic               clk_i,
	// Device side
	input  wire gpr_pkg::gpr_pins_s pin_out_i,
	input  wire gpr_pkg::gpr_pins_s pin_oe_i,
	input  wire logic [15:0]        pullup_a_i,
	// Board side
	input  wire gpr_pkg::gpr_pins_s ext_lvl_i,
	input  wire gpr_pkg::gpr_pins_s ext_en_i,
	output      gpr_pkg::gpr_pins_s pin_lvl_o
);
	// ----------------------------------------
	// Pin levels
	// ----------------------------------------
	logic [59:0] flt = 60'h0;
	logic [59:0] pu;
	logic [59:0] hiz;

	// Floating lines change every cycle
	always @(posedge clk_i)
		flt <= ~flt;

	assign pu  = {pullup_a_i, 44'h0};
	assign hiz = ~pin_oe_i & ~ext_en_i;
	// Device drive, board drive, pull-up, float
	assign pin_lvl_o = (pin_oe_i & pin_out_i) | (~pin_oe_i & ext_en_i & ext_lvl_i)
		| (hiz & pu) | (hiz & ~pu & flt);
endmodule

// File: gpr_regs_test.sv
`timescale 1ns/10ps

module gpr_regs_test;
	// ----------------------------------------
	// Signals
	// ----------------------------------------
	logic               clk      = 1'b0;
	logic               rst      = 1'b1;
	logic               cyc      = 1'b0;
	logic               stb      = 1'b0;
	logic               we       = 1'b0;
	logic [7:0]         adr      = 8'h00;
	logic [31:0]        wdat     = 32'h0;
	logic [3:0]         sel      = 4'hf;
	logic [15:0]        dir_a    = 16'h0000;
	logic [15:0]        dir_b    = 16'h0000;
	logic [31:0]        rdat;
	logic               ack;
	logic [31:0]        q;
	logic [15:0]        pu_a;
	gpr_pkg::gpr_pins_s lvl;
	gpr_pkg::gpr_pins_s pout;
	gpr_pkg::gpr_pins_s poe;
	gpr_pkg::gpr_pins_s ext;
	gpr_pkg::gpr_pins_s ext_en;
	int                 n_errors = 0;
	int                 n_checks = 0;
	logic [7:0]         ta[8]    = '{8'h08, 8'h0c, 8'h18, 8'h1c, 8'h10, 8'h14, 8'h20, 8'h40};
	logic [31:0]        tw[8]    = '{32'hffff0000, 32'hfffff000, 32'h1234abcd, 32'hfffff5a5,
		32'h00000f0f, 32'hffffffff, 32'hffff5555, 32'hffffffff};
	logic [31:0]        te[8]    = '{32'h0, 32'h0, 32'habcd, 32'h5a5, 32'h0f0f, 32'hfffe, 32'h5555, 32'h0};

	always #12.5 clk = ~clk;

	gpr_regs u_gpr_regs (.clk_i(clk), .rst_i(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
		.wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
		.dir_a_i(dir_a), .dir_b_i(dir_b), .pin_lvl_i(lvl), .pin_out_o(pout), .pin_oe_o(poe),
		.pullup_a_o(pu_a));

	gpr_pin_model u_gpr_pin_model (.clk_i(clk), .pin_out_i(pout), .pin_oe_i(poe), .pullup_a_i(pu_a),
		.ext_lvl_i(ext), .ext_en_i(ext_en), .pin_lvl_o(lvl));

	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
		n_checks++;
		if (seen !== exp)
		begin
			n_errors++;
			$display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		@(posedge clk);
		while (ack !== 1'b1 && n < 20)
		begin
			@(posedge clk);
			n++;
		end
		q = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
		if (n >= 20)
			n_errors++;
		@(posedge clk);
	endtask

	task automatic chk_rd(input logic [7:0] a, input logic [31:0] exp);
		xfer(1'b0, a, 32'h0);
		chk({32'h0, q}, {32'h0, exp});
	endtask

	task automatic conclude;
		$display("checks %0d errors %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	// ----------------------------------------
	// Tests
	// ----------------------------------------
	initial
	begin
		ext = '0;
		ext_en = '0;
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		chk_rd(8'h08, 32'h0000ffff);
		chk_rd(8'h0c, 32'h00000fff);
		chk_rd(8'h10, 32'h0000ffff);
		chk_rd(8'h14, 32'h0000fffe);
		chk_rd(8'h20, 32'h0);
		chk_rd(8'h38, 32'h0);
		chk({4'h0, poe}, 64'h0);
		xfer(1'b1, 8'h08, 32'h0);
		chk_rd(8'h08, 32'h0000ffff);
		$display("test reset done");
		xfer(1'b1, 8'h38, 32'h00400000);
		chk_rd(8'h38, 32'h00400000);
		for (int i = 0; i < 8; i++)
		begin
			xfer(1'b1, ta[i], tw[i]);
			chk_rd(ta[i], te[i]);
		end
		chk({48'h0, poe.c}, 64'hffff);
		chk({52'h0, poe.d}, 64'hfff);
		chk({48'h0, pout.c}, 64'habcd);
		chk({52'h0, pout.d}, 64'h5a5);
		chk({48'h0, pout.a}, 64'h0f0f);
		chk({48'h0, poe.a}, 64'hffff);
		chk({48'h0, pout.b}, 64'hfffe);
		chk({48'h0, pu_a}, 64'h5555);
		$display("test write read done");
		ext_en.c <= 16'hffff;
		ext.c <= 16'h3c3c;
		xfer(1'b1, 8'h08, 32'h0000ffff);
		repeat (5) @(posedge clk);
		chk_rd(8'h18, 32'h3c3c);
		chk({48'h0, poe.c}, 64'h0);
		sel <= 4'h1;
		xfer(1'b1, 8'h18, 32'h000000ff);
		sel <= 4'hf;
		chk({48'h0, pout.c}, 64'habff);
		$display("test input read done");
		xfer(1'b1, 8'h38, 32'h0);
		chk({4'h0, poe}, 64'h0);
		chk({48'h0, pu_a}, 64'h0);
		$display("test gate off done");
		rst <= 1'b1;
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		chk_rd(8'h0c, 32'h00000fff);
		chk_rd(8'h08, 32'h0000ffff);
		$display("test second reset done");
		conclude();
	end

	initial
	begin
		#50000;
		n_errors++;
		conclude();
	end
endmodule
